// [cpu_core_model.sv]
// Purpose: behavioural CPU core producing change-of-flow traffic
// Assumes: one clock; outputs change just after the rising edge
// Notes: halts on a break request until run_i drops
module cpu_core_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic brk_i,
    output logic [1:0] cof_o,
    output logic [16:0] addr_o,
    output logic halted_o
);
    initial
    begin
        cof_o = 2'h0;
        addr_o = 17'h00000;
        halted_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        // Fresh address each cycle so a stale value never matches by luck
        addr_o <= 17'($urandom);
        halted_o <= run_i && (halted_o || brk_i);
        cof_o <= (run_i && !halted_o && !brk_i) ? 2'($urandom_range(2, 0)) : 2'h0;
    end
endmodule // cpu_core_model

// [testbench.sv]
// Purpose: self-checking bench for trace_ctrl with a CPU core model
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: FIFO contents are predicted from observed core traffic
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i = 1'b1, end_run_reset_i = 1'b0, ctrl_wr_i = 1'b0, trig_wr_i = 1'b0;
    logic [7:0] ctrl_wdata_i = 8'h00, trig_wdata_i = 8'h00, data_bus_i = 8'h00;
    logic match_a_i = 1'b0, match_b_i = 1'b0, qual_a_i = 1'b0, rd_low_i = 1'b0, run_i = 1'b0;
    // Tied: paged memory and comparator B opcode tracking stay untested
    logic qual_b_i = 1'b0, irq_pending_i = 1'b0, core_paged_i = 1'b0, opcode_paged_i = 1'b0;
    logic [16:0] opcode_addr_i = 17'h00000, prev_addr = 17'h00000, op0;
    wire logic [1:0] core_cof_i;
    wire logic [16:0] core_addr_i;
    wire logic [7:0] debug_control_reg_o, trigger_control_reg_o, fifo_extended_byte_o;
    wire logic [7:0] fifo_high_byte_o, fifo_low_byte_o;
    wire logic [23:0] comp_a_o;
    wire logic [3:0] valid_word_count_o;
    wire logic armed_flag_o, comp_a_match_flag_o, comp_b_match_flag_o, force_break_o, tag_break_o;
    logic mon_on = 1'b0;
    logic [16:0] exp_q[$];
    int num_errors = 0, checked = 0, n_force = 0, n_tag = 0;
    int modes[3] = '{7, 8, 3};
    logic [15:0] cfg[6] = '{16'h80F0, 16'h00C0, 16'h80E0, 16'h40C0, 16'h40D0, 16'hC0D0};
    trace_ctrl #(.DEPTH(16)) i_trace_ctrl (.*);
    cpu_core_model i_cpu_core_model (.clk_i, .run_i, .brk_i(force_break_o | tag_break_o),
        .cof_o(core_cof_i), .addr_o(core_addr_i), .halted_o());
    function automatic logic [16:0] stored(input logic [1:0] c, input logic [16:0] a, p);
        return c[1] ? a : p - 17'h00002;
    endfunction
    function automatic logic [1:0] expf(input int m, input int s);
        case (m)
            7: return (s == 2) ? 2'b11 : 2'b00;
            8: return (s == 0) ? 2'b10 : 2'b11;
            default: return (s == 0) ? 2'b00 : 2'b01;
        endcase
    endfunction
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        prev_addr <= core_addr_i;
        if (mon_on && core_cof_i != 2'h0)
            exp_q.push_back(stored(core_cof_i, core_addr_i, prev_addr));
        if (force_break_o)
            n_force++;
        if (tag_break_o)
            n_tag++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] t, input logic [7:0] c);
        trig_wdata_i <= t;
        ctrl_wdata_i <= c;
        trig_wr_i <= 1'b1;
        ctrl_wr_i <= 1'b1;
        @(posedge clk_i);
        trig_wr_i <= 1'b0;
        ctrl_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic hit(input logic a, input logic b, input logic q);
        match_a_i <= a;
        match_b_i <= b;
        qual_a_i <= q;
        @(posedge clk_i);
        match_a_i <= 1'b0;
        match_b_i <= 1'b0;
        qual_a_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic defaults();
        check(comp_a_o, 24'h00FFFE);
        check(debug_control_reg_o, 8'hC0);
        check(trigger_control_reg_o, 8'h40);
        check(armed_flag_o, 1'b1);
    endtask
    task automatic run(input logic [7:0] t, input logic [7:0] c);
        int f0 = n_force;
        int t0 = n_tag;
        wr(t, c);
        exp_q.delete();
        mon_on <= !t[6];
        run_i <= !t[6];
        repeat (30) @(posedge clk_i);
        run_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        mon_on <= 1'b0;
        hit(1'b1, 1'b0, 1'b1);
        mon_on <= t[6];
        run_i <= t[6];
        for (int i = 0; i < 300 && armed_flag_o === 1'b1; i++)
            @(posedge clk_i);
        run_i <= 1'b0;
        mon_on <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(n_force - f0, 32'(c[4] & ~c[5]));
        check(n_tag - t0, 32'(c[4] & c[5]));
        check(armed_flag_o, 1'b0);
        check(valid_word_count_o, 4'h8);
        while (!t[6] && exp_q.size() > 8)
            exp_q.pop_front();
        for (int k = 0; k < 8; k++)
        begin
            check({fifo_extended_byte_o, fifo_high_byte_o, fifo_low_byte_o}, {7'h00, exp_q[k]});
            opcode_addr_i <= 17'($urandom);
            rd_low_i <= 1'b1;
            @(posedge clk_i);
            // Only the last sample survives, since it shows once the FIFO is empty
            op0 = opcode_addr_i;
            rd_low_i <= 1'b0;
            @(posedge clk_i);
        end
        check(valid_word_count_o, 4'h8);
        check({fifo_extended_byte_o, fifo_high_byte_o, fifo_low_byte_o}, {7'h00, op0});
    endtask
    initial
    begin
        void'($urandom(32'hABC5));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        defaults();
        run(8'h00, 8'hD0);
        end_run_reset_i <= 1'b1;
        rst_i <= 1'b1;
        @(posedge clk_i);
        end_run_reset_i <= 1'b0;
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(debug_control_reg_o, 8'h80);
        check(valid_word_count_o, 4'h8);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        defaults();
        foreach (modes[j])
        begin
            wr({4'h4, 4'(modes[j])}, 8'hC0);
            for (int s = 0; s < 3; s++)
            begin
                hit(s != 1, s != 0, 1'b0);
                check({comp_a_match_flag_o, comp_b_match_flag_o}, expf(modes[j], s));
            end
        end
        // Pending interrupt: a qualified trigger is lost, an unqualified one is taken
        wr(8'h80, 8'hC0);
        irq_pending_i <= 1'b1;
        hit(1'b1, 1'b0, 1'b1);
        check({armed_flag_o, comp_a_match_flag_o}, 2'b10);
        wr(8'h00, 8'hC0);
        hit(1'b1, 1'b0, 1'b0);
        irq_pending_i <= 1'b0;
        check({armed_flag_o, comp_a_match_flag_o}, 2'b01);
        wr(8'h40, 8'h80);
        check(armed_flag_o, 1'b0);
        foreach (cfg[j])
            run(cfg[j][15:8], cfg[j][7:0]);
        give_verdict();
    end
    initial
    begin
        // Roughly twenty times the expected length of all tests
        #50000;
        num_errors++;
        give_verdict();
    end
endmodule // testbench

// [trace_ctrl.sv]
// Purpose: trigger and break controller with trace capture
// Assumes: comparator matches arrive from same-clock logic
// Notes: host access uses read strobes and write strobes as ports
`include "trace_defs.svh"
module trace_ctrl #(
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic end_run_reset_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic trig_wr_i,
    input wire logic [7:0] trig_wdata_i,
    input wire logic match_a_i,
    input wire logic match_b_i,
    input wire logic qual_a_i,
    input wire logic qual_b_i,
    input wire logic irq_pending_i,
    input wire logic [1:0] core_cof_i,
    input wire logic [16:0] core_addr_i,
    input wire logic core_paged_i,
    input wire logic [7:0] data_bus_i,
    input wire logic [16:0] opcode_addr_i,
    input wire logic opcode_paged_i,
    input wire logic rd_low_i,
    output logic [7:0] debug_control_reg_o,
    output logic [7:0] trigger_control_reg_o,
    output logic [23:0] comp_a_o,
    output logic armed_flag_o,
    output logic comp_a_match_flag_o,
    output logic comp_b_match_flag_o,
    output logic [3:0] valid_word_count_o,
    output logic [7:0] fifo_extended_byte_o,
    output logic [7:0] fifo_high_byte_o,
    output logic [7:0] fifo_low_byte_o,
    output logic force_break_o,
    output logic tag_break_o
);
    logic [7:0] ctrl_r;
    logic [7:0] trig_r;
    logic [23:0] cmp_a_r;
    logic armed_flag_r;
    logic af_r;
    logic bf_r;
    logic [3:0] cnt_r;
    logic triggered_r;
    logic [16:0] prev_addr_r;
    logic brk_r;
    logic tag_r;
    trace_pkg::run_state_t state_r;
    trace_pkg::run_state_t state_nxt;
    trace_pkg::trace_word_t head_r;
    logic [7:0] ctrl_nxt;

    function automatic logic is_event(input logic [3:0] code);
        return (code == trace_pkg::MODE_EVENT_B) || (code == trace_pkg::MODE_A_THEN_EVENT_B);
    endfunction

    wire en = ctrl_r[`CTRL_EN_BIT];
    wire arm = ctrl_r[`CTRL_ARM_BIT];
    wire tag = ctrl_r[`CTRL_TAG_BIT];
    wire brk_en = ctrl_r[`CTRL_BRK_BIT];
    wire opcode_qualify_select = trig_r[`TRIG_QUAL_BIT];
    trace_pkg::trig_mode_t mode;
    assign mode = trace_pkg::trig_mode_t'(trig_r[`TRIG_MODE_LSB +: `TRIG_MODE_W]);
    wire event_only = is_event(mode);
    // Arming together with a new trigger setting must start in that setting's type
    wire [7:0] trig_nxt = trig_wr_i ? trig_wdata_i : trig_r;
    wire begin_nxt = trig_nxt[`TRIG_BEGIN_BIT] ||
        is_event(trig_nxt[`TRIG_MODE_LSB +: `TRIG_MODE_W]);
    wire begin_type = trig_r[`TRIG_BEGIN_BIT] || event_only;
    wire armed = en && arm && armed_flag_r;

    // Qualified matches lose to a pending interrupt at the pipe top
    wire hit_a = opcode_qualify_select ? (qual_a_i && !irq_pending_i) : match_a_i;
    wire hit_b = opcode_qualify_select ? (qual_b_i && !irq_pending_i) : match_b_i;
    wire range_both = hit_a && hit_b;
    wire set_a = (mode == trace_pkg::MODE_INSIDE || mode == trace_pkg::MODE_A_AND_B ||
        mode == trace_pkg::MODE_A_AND_NOT_B) ? range_both :
        (mode == trace_pkg::MODE_EVENT_B) ? 1'b0 : hit_a;
    wire set_b = (mode == trace_pkg::MODE_INSIDE || mode == trace_pkg::MODE_A_AND_B ||
        mode == trace_pkg::MODE_A_AND_NOT_B) ? range_both :
        (mode == trace_pkg::MODE_A_ONLY) ? 1'b0 :
        (mode == trace_pkg::MODE_A_THEN_B || mode == trace_pkg::MODE_A_THEN_EVENT_B) ?
        (hit_b && af_r) : hit_b;
    wire trigger = armed && (
        (mode == trace_pkg::MODE_A_ONLY) ? set_a :
        (mode == trace_pkg::MODE_A_OR_B || mode == trace_pkg::MODE_OUTSIDE) ? (set_a || set_b) :
        set_b);

    // Flow address selection
    wire [16:0] branch_src = prev_addr_r - `BRANCH_BACKUP;
    wire [16:0] cof_addr = core_cof_i[1] ? core_addr_i : branch_src;
    wire cof_hit = |core_cof_i;
    wire ev_store = event_only && set_b;
    trace_pkg::trace_word_t store_word;
    assign store_word = event_only ?
        trace_pkg::trace_word_t'{paged: 1'b0, addr: {9'h000, data_bus_i}} :
        trace_pkg::trace_word_t'{paged: core_paged_i, addr: cof_addr};
    wire store_ok = (state_r == trace_pkg::ST_STORE) ||
        (begin_type && trigger && state_r == trace_pkg::ST_WAIT);
    wire store = armed && store_ok && (event_only ? ev_store : cof_hit);
    wire full = (cnt_r == 4'(`FIFO_WORDS)) || (begin_type && cnt_r == 4'(`FIFO_WORDS - 1) && store);
    wire begin_done = begin_type && store && (cnt_r == 4'(`FIFO_WORDS - 1));
    wire end_done = !begin_type && trigger;
    wire disarm = armed && (begin_done || end_done);

    // FIFO path; the storage keeps the eight newest words
    logic f_in_ready;
    logic f_out_valid;
    trace_pkg::trace_word_t f_out;
    wire f_full_drop = (cnt_r == 4'(`FIFO_WORDS)) && store;
    wire host_pop = rd_low_i && !armed && en && f_out_valid;
    wire arm_write = ctrl_wr_i && ctrl_wdata_i[`CTRL_ARM_BIT] && ctrl_wdata_i[`CTRL_EN_BIT];
    trace_fifo #(.WIDTH(18), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i && !end_run_reset_i),
        .clr_i(arm_write),
        .in_valid_i(store && f_in_ready),
        .in_ready_o(f_in_ready),
        .in_data_i(store_word),
        .out_valid_o(f_out_valid),
        .out_ready_i(host_pop || f_full_drop),
        .out_data_o(f_out)
    );

    always_comb
    begin
        ctrl_nxt = ctrl_wr_i ? ctrl_wdata_i : ctrl_r;
        if (disarm)
        begin
            ctrl_nxt[`CTRL_ARM_BIT] = 1'b0;
        end
    end

    always_comb
    begin
        case (state_r)
            trace_pkg::ST_IDLE: state_nxt = trace_pkg::ST_IDLE;
            trace_pkg::ST_WAIT: state_nxt = !armed ? trace_pkg::ST_IDLE :
                (trigger ? trace_pkg::ST_STORE : trace_pkg::ST_WAIT);
            trace_pkg::ST_STORE: state_nxt = (!armed || disarm) ? trace_pkg::ST_IDLE :
                trace_pkg::ST_STORE;
            default: state_nxt = trace_pkg::ST_IDLE;
        endcase
        // Re-arming restarts the run from any state
        if (arm_write)
        begin
            state_nxt = begin_nxt ? trace_pkg::ST_WAIT : trace_pkg::ST_STORE;
        end
    end

    // Reset never originates here; end-run reset keeps results for readout
    always_ff @(posedge clk_i)
    begin
        if (rst_i && end_run_reset_i)
        begin
            ctrl_r[`CTRL_ARM_BIT] <= 1'b0;
            ctrl_r[`CTRL_BRK_BIT] <= 1'b0;
            armed_flag_r <= 1'b0;
            state_r <= trace_pkg::ST_IDLE;
            brk_r <= 1'b0;
            tag_r <= 1'b0;
        end
        else if (rst_i)
        begin
            cmp_a_r <= {`CMP_A_EXT_RST, `CMP_A_HIGH_RST, `CMP_A_LOW_RST};
            ctrl_r <= `DBG_CTRL_RST;
            trig_r <= `TRIG_CTRL_RST;
            armed_flag_r <= 1'b1;
            af_r <= 1'b0;
            bf_r <= 1'b0;
            cnt_r <= 4'h0;
            state_r <= trace_pkg::ST_WAIT;
            brk_r <= 1'b0;
            tag_r <= 1'b0;
            head_r <= '0;
            prev_addr_r <= 17'h00000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            trig_r <= trig_wr_i ? trig_wdata_i : trig_r;
            state_r <= state_nxt;
            prev_addr_r <= core_addr_i;
            armed_flag_r <= arm_write ? 1'b1 : (ctrl_nxt[`CTRL_ARM_BIT] && ctrl_nxt[`CTRL_EN_BIT] &&
                armed_flag_r && !disarm);
            af_r <= arm_write ? 1'b0 : (af_r || (armed && set_a));
            bf_r <= arm_write ? 1'b0 : (bf_r || (armed && set_b));
            if (arm_write)
            begin
                cnt_r <= 4'h0;
            end
            else if (store && !full)
            begin
                cnt_r <= cnt_r + 4'h1;
            end
            else if (store && cnt_r != 4'(`FIFO_WORDS))
            begin
                cnt_r <= cnt_r + 4'h1;
            end
            // Break only with enable; tag ignored otherwise
            brk_r <= brk_en && !tag && ((begin_type && begin_done) ||
                (!begin_type && !opcode_qualify_select && trigger));
            tag_r <= brk_en && tag && !begin_type && trigger;
            // Head follows oldest while disarmed, frozen when armed; disarmed read latches profile sample
            if (rd_low_i && !armed)
            begin
                head_r <= '{paged: opcode_paged_i, addr: opcode_addr_i};
            end
            else if (f_out_valid && !armed)
            begin
                head_r <= f_out;
            end
        end
    end

    // Armed reads see oldest entry but never shift it
    trace_pkg::trace_word_t read_word;
    assign read_word = (armed || !f_out_valid) ? (f_out_valid ? f_out : head_r) : f_out;
    assign fifo_low_byte_o = read_word.addr[7:0];
    assign fifo_high_byte_o = event_only ? 8'h00 : read_word.addr[15:8];
    assign fifo_extended_byte_o = event_only ? 8'h00 :
        {6'h00, read_word.paged, read_word.addr[16]};
    assign debug_control_reg_o = ctrl_r;
    assign trigger_control_reg_o = trig_r;
    assign comp_a_o = cmp_a_r;
    assign armed_flag_o = armed_flag_r;
    assign comp_a_match_flag_o = af_r;
    assign comp_b_match_flag_o = bf_r;
    assign valid_word_count_o = cnt_r;
    assign force_break_o = brk_r;
    assign tag_break_o = tag_r;
endmodule // trace_ctrl

// [trace_ctrl_sva.sv]
// Purpose: port-level assertions for trace_ctrl
// Assumes: one clock, rst_i synchronous active high
// Notes: flags and breaks are judged one edge after their cause
module trace_ctrl_sva #(
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic end_run_reset_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wdata_i,
    input wire logic match_b_i,
    input wire logic rd_low_i,
    input wire logic [7:0] debug_control_reg_o,
    input wire logic [7:0] trigger_control_reg_o,
    input wire logic [23:0] comp_a_o,
    input wire logic armed_flag_o,
    input wire logic comp_a_match_flag_o,
    input wire logic comp_b_match_flag_o,
    input wire logic [3:0] valid_word_count_o,
    input wire logic [7:0] fifo_extended_byte_o,
    input wire logic [7:0] fifo_high_byte_o,
    input wire logic force_break_o,
    input wire logic tag_break_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic [3:0] mode = trigger_control_reg_o[3:0];
    rst_vals_a: assert property ($fell(rst_i) && !$past(end_run_reset_i) |->
        comp_a_o == 24'h00FFFE && debug_control_reg_o == 8'hC0
        && trigger_control_reg_o == 8'h40 && armed_flag_o) else $error("default reset wrong");
    end_run_keep_a: assert property ($fell(rst_i) && $past(end_run_reset_i) |->
        !armed_flag_o && !debug_control_reg_o[6] && !debug_control_reg_o[4])
        else $error("end-run reset wrong");
    inside_pair_a: assert property (mode == 4'h7 && $rose(comp_a_match_flag_o) |->
        $rose(comp_b_match_flag_o)) else $error("inside flags split");
    outside_b_a: assert property (mode == 4'h8 && !trigger_control_reg_o[7]
        && $rose(comp_b_match_flag_o) |-> $past(match_b_i)) else $error("outside b flag");
    break_off_a: assert property (!debug_control_reg_o[4] |=>
        !force_break_o && !tag_break_o) else $error("break while disabled");
    tag_off_a: assert property (!debug_control_reg_o[5] |=> !tag_break_o)
        else $error("tag break without tag");
    count_step_a: assert property (valid_word_count_o != $past(valid_word_count_o) |->
        valid_word_count_o == $past(valid_word_count_o) + 4'h1 || valid_word_count_o == 4'h0)
        else $error("count step wrong");
    count_cap_a: assert property (valid_word_count_o <= 4'h8)
        else $error("count above eight");
    arm_clear_a: assert property (ctrl_wr_i && ctrl_wdata_i[7:6] == 2'b11 |=>
        valid_word_count_o == 4'h0 && !comp_a_match_flag_o && !comp_b_match_flag_o)
        else $error("arm did not clear");
    armed_off_a: assert property (ctrl_wr_i && ctrl_wdata_i[7:6] != 2'b11 |=>
        !armed_flag_o) else $error("armed flag kept");
    event_zero_a: assert property (mode inside {4'h3, 4'h4} |->
        fifo_high_byte_o == 8'h00 && fifo_extended_byte_o == 8'h00) else $error("event bytes");
    cover property (force_break_o);
    cover property (tag_break_o);
    cover property (valid_word_count_o == 4'h8 && !armed_flag_o);
    cover property (rd_low_i && !armed_flag_o);
endmodule // trace_ctrl_sva
bind trace_ctrl trace_ctrl_sva #(.DEPTH(DEPTH)) i_trace_ctrl_sva (.clk_i, .rst_i,
    .end_run_reset_i, .ctrl_wr_i, .ctrl_wdata_i, .match_b_i, .rd_low_i, .debug_control_reg_o,
    .trigger_control_reg_o, .comp_a_o, .armed_flag_o, .comp_a_match_flag_o,
    .comp_b_match_flag_o, .valid_word_count_o, .fifo_extended_byte_o, .fifo_high_byte_o,
    .force_break_o, .tag_break_o);

// [trace_defs.svh]
// Purpose: constants for the debug trace FIFO and trigger controller
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: no register bus; control and status bits are ports
`ifndef TRACE_DEFS_SVH
`define TRACE_DEFS_SVH
`define CMP_A_EXT_RST 8'h00
`define CMP_A_HIGH_RST 8'hFF
`define CMP_A_LOW_RST 8'hFE
`define DBG_CTRL_RST 8'hC0
`define TRIG_CTRL_RST 8'h40
`define CTRL_EN_BIT 7
`define CTRL_ARM_BIT 6
`define CTRL_TAG_BIT 5
`define CTRL_BRK_BIT 4
`define TRIG_QUAL_BIT 7
`define TRIG_BEGIN_BIT 6
`define TRIG_MODE_LSB 0
`define TRIG_MODE_W 4
`define FIFO_WORDS 8
`define BRANCH_BACKUP 17'h00002
`endif

// [trace_fifo.sv]
// Purpose: trace storage FIFO, flip-flop array with index pointers
// Assumes: single clock; overwrite of oldest done by caller draining
// Notes: ready low when full so the source stalls
module trace_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] fill_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (fill_r != (AW+1)'(DEPTH));
    assign out_valid_o = (fill_r != '0);
    assign out_data_o = mem_r[rd_r];
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clr_i)
        begin
            wr_r <= '0;
            rd_r <= '0;
            fill_r <= '0;
        end
        else
        begin
            wr_r <= push ? wr_r + 1'b1 : wr_r;
            rd_r <= pop ? rd_r + 1'b1 : rd_r;
            fill_r <= fill_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // trace_fifo

// [trace_pkg.sv]
// Purpose: types for the debug trace block
// Assumes: constants come from trace_defs.svh
// Notes: mode codes are an internal choice
package trace_pkg;
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'h0,
        MODE_A_OR_B = 4'h1,
        MODE_A_THEN_B = 4'h2,
        MODE_EVENT_B = 4'h3,
        MODE_A_THEN_EVENT_B = 4'h4,
        MODE_A_AND_B = 4'h5,
        MODE_A_AND_NOT_B = 4'h6,
        MODE_INSIDE = 4'h7,
        MODE_OUTSIDE = 4'h8
    } trig_mode_t;
    typedef struct packed {
        logic paged;
        logic [16:0] addr;
    } trace_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_STORE = 3'b100
    } run_state_t;
endpackage
